// >>> rtl/cgc_consts.svh
/*
 Constants for the clock generator control block: register offsets,
 field positions, reset values and timing counts.
 Assumes it is included by bare name from any source on the include path.
*/
`ifndef CGC_CONSTS_SVH
`define CGC_CONSTS_SVH

// Wishbone byte offsets of the three registers.
`define CGC_OFS_SCC 8'h00
`define CGC_OFS_LPC 8'h04
`define CGC_OFS_STAT 8'h08

// System clock control fields.
`define CGC_SCC_STOP_BIT 7
`define CGC_SCC_SWMODE_BIT 3
`define CGC_SCC_SEL_HI 2
`define CGC_SCC_SEL_LO 0
`define CGC_SCC_WMASK 8'h8f

// Low power control fields.
`define CGC_LPC_SUBOFF_BIT 4
`define CGC_LPC_FBCUT_BIT 3
`define CGC_LPC_MUL_HI 1
`define CGC_LPC_MUL_LO 0

// Reset values of both registers.
`define CGC_SCC_RESET 8'h00
`define CGC_LPC_RESET 8'h00

// Bus clock select codes that mean full speed and the prohibited pair.
`define CGC_SEL_FULL 3'h0
`define CGC_SEL_BAD_HI 2'h3

// Prohibited multiplier code.
`define CGC_MUL_BAD 2'h3

// Subclock is the oscillator divided by 128; the square wave is taken
// from bit 6 of the free running divider.
`define CGC_SUB_DIVIDE 128
`define CGC_SUB_BIT 6
`define CGC_DIV_W 7

// Default settle unit in cycles; real time is unit shifted by the
// three standby settling-time bits.
`define CGC_SETTLE_UNIT 32'd256
`define CGC_SETTLE_W 16

`endif

// >>> rtl/cgc_pkg.sv
/*
 Types for the clock generator control block.
 Assumes cgc_consts.svh sits beside it.
*/
`default_nettype none
package cgc_pkg;

   // Operating mode reported by the power-down controller.
   typedef enum logic [3:0] {
      CGC_MODE_HIGH,
      CGC_MODE_MEDIUM,
      CGC_MODE_SUBACTIVE,
      CGC_MODE_SLEEP,
      CGC_MODE_SUBSLEEP,
      CGC_MODE_WATCH,
      CGC_MODE_SW_STANDBY,
      CGC_MODE_HW_STANDBY,
      CGC_MODE_DIRECT
   } cgc_mode_t;

   // Multiplier sequencing state.
   typedef enum logic [1:0] {
      CGC_PLL_RUN,
      CGC_PLL_STANDBY,
      CGC_PLL_SETTLE
   } cgc_pll_state_t;

endpackage : cgc_pkg
`default_nettype wire

// >>> rtl/cgc_div_if.sv
/*
 Interface between the control top and its divider.
 Assumes both ends share clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cgc_consts.svh"
interface cgc_div_if;
   logic [`CGC_DIV_W-1:0] count;
   logic sub_enable;
   logic sub_clk;

   modport divider (output count, output sub_clk, input sub_enable);
   modport ctrl (input count, input sub_clk, output sub_enable);
endinterface : cgc_div_if
`default_nettype wire

// >>> rtl/cgc_divider.sv
/*
 Free running divider that feeds the medium speed and subclock taps.
 Assumes clock_i is the oscillator clock and rst_i is synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cgc_consts.svh"
module cgc_divider
   import cgc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   cgc_div_if.divider div
);

   logic [`CGC_DIV_W-1:0] count_r;
   logic sub_clk_r;

   ////////////////////////////////////////////////////////////////////
   // The counter never stops so the medium speed taps stay in phase.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   // Subclock square wave; held low while generation is disabled.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sub_clk_r <= 1'b0;
      end else if (div.sub_enable) begin
         sub_clk_r <= count_r[`CGC_SUB_BIT];
      end else begin
         sub_clk_r <= 1'b0;
      end
   end

   assign div.count = count_r;
   assign div.sub_clk = sub_clk_r;

endmodule : cgc_divider
`default_nettype wire

// >>> rtl/cgc_top.sv
/*
 Clock generator control: system clock control and low power control
 registers on a classic Wishbone slave, clock output pin control,
 bus master clock select, subclock enable, feedback resistor control
 and deferred or immediate multiplier switching.
 Assumes mode_i and settle_time_i come from logic on clock_i, and that
 the pad cell forwards the system clock while sys_clk_pass_o is high.
*/
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cgc_consts.svh"
module cgc_top
   import cgc_pkg::*;
#(
   parameter logic [31:0] SETTLE_UNIT = `CGC_SETTLE_UNIT
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Operating mode and standby settling selection.
   input wire cgc_mode_t mode_i,
   input wire logic [2:0] settle_time_i,
   // System clock output pin.
   output logic sys_clk_pass_o,
   output logic sys_clk_out_o,
   output logic sys_clk_oe_o,
   // Clock products.
   output logic bm_clk_en_o,
   output logic [2:0] bm_clk_div_o,
   output logic sub_clk_o,
   output logic sub_clk_en_o,
   output logic feedback_on_o,
   output logic [1:0] pll_factor_o,
   output logic pll_settling_o
);

   ////////////////////////////////////////////////////////////////////
   // Storage.
   logic [7:0] scc_r;
   logic [7:0] lpc_r;
   logic [1:0] pll_factor_r;
   logic fb_cut_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic bm_en_r;
   logic [2:0] bm_div_r;
   logic pass_r;
   logic out_r;
   logic oe_r;
   logic fb_on_r;
   logic [`CGC_SETTLE_W-1:0] settle_r;
   logic [`CGC_SETTLE_W-1:0] settle_nxt;
   cgc_pll_state_t pll_st_r;
   cgc_mode_t mode_prev_r;

   logic bus_req;
   logic wr_now;
   logic wr_scc;
   logic wr_lpc;
   logic [7:0] rd_val;
   logic enter_sby;
   logic leave_sby;
   logic osc_stopped;
   logic active_mode;
   logic [2:0] sel;
   logic [1:0] mul_req;
   logic mul_ok;
   logic [1:0] mul_wr;
   logic [`CGC_DIV_W-1:0] tap_mask;

   cgc_div_if div ();

   cgc_divider u_div (
      .clock_i (clock_i),
      .rst_i (rst_i),
      .div (div.divider)
   );

   ////////////////////////////////////////////////////////////////////
   // Bus decode. A write lands on the edge at which ack is sampled, so
   // the master sees the new value on the very next read.
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_now = bus_req & wb_we_i & ack_r & wb_sel_i[0];
   assign wr_scc = wr_now & (wb_adr_i == `CGC_OFS_SCC);
   assign wr_lpc = wr_now & (wb_adr_i == `CGC_OFS_LPC);

   // Ack one cycle after the request, dropped the cycle after.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // Read multiplexer; unmapped offsets answer with zero.
   always_comb begin
      rd_val = 8'h00;
      case (wb_adr_i)
         `CGC_OFS_SCC: rd_val = scc_r & `CGC_SCC_WMASK;
         `CGC_OFS_LPC: rd_val = lpc_r;
         `CGC_OFS_STAT: rd_val = {1'b0, pll_settling_o, fb_cut_r,
                                  sub_clk_en_o, mode_i};
         default: rd_val = 8'h00;
      endcase
   end

   // Read data is captured as ack rises and held until the next answer.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else if (bus_req & ~ack_r) begin
         dat_r <= {24'h00_0000, rd_val};
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   ////////////////////////////////////////////////////////////////////
   // System clock control register; reserved bits are masked on write.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scc_r <= `CGC_SCC_RESET;
      end else if (wr_scc) begin
         scc_r <= wb_dat_i[7:0] & `CGC_SCC_WMASK;
      end
   end

   // Low power control register. Bits 5 and 2 are stored as written;
   // software is expected to keep them zero.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         lpc_r <= `CGC_LPC_RESET;
      end else if (wr_lpc) begin
         lpc_r <= wb_dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mode classification and standby edges.
   assign active_mode = (mode_i == CGC_MODE_HIGH) |
                        (mode_i == CGC_MODE_MEDIUM) |
                        (mode_i == CGC_MODE_SUBACTIVE) |
                        (mode_i == CGC_MODE_SLEEP) |
                        (mode_i == CGC_MODE_SUBSLEEP);
   assign osc_stopped = (mode_i == CGC_MODE_SW_STANDBY) |
                        (mode_i == CGC_MODE_WATCH) |
                        (mode_i == CGC_MODE_HW_STANDBY);
   assign enter_sby = (mode_i == CGC_MODE_SW_STANDBY) &
                      (mode_prev_r != CGC_MODE_SW_STANDBY);
   assign leave_sby = (mode_i != CGC_MODE_SW_STANDBY) &
                      (mode_prev_r == CGC_MODE_SW_STANDBY);

   // Previous mode for edge detection.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         mode_prev_r <= CGC_MODE_HIGH;
      end else begin
         mode_prev_r <= mode_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Clock output pin. Registered so the pad control never glitches.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pass_r <= 1'b0;
         out_r <= 1'b1;
         oe_r <= 1'b0;
      end else if (mode_i == CGC_MODE_HW_STANDBY) begin
         pass_r <= 1'b0;
         out_r <= 1'b1;
         oe_r <= 1'b0;
      end else if (active_mode) begin
         pass_r <= ~scc_r[`CGC_SCC_STOP_BIT];
         out_r <= 1'b1;
         oe_r <= 1'b1;
      end else begin
         pass_r <= 1'b0;
         out_r <= 1'b1;
         oe_r <= 1'b1;
      end
   end

   assign sys_clk_pass_o = pass_r;
   assign sys_clk_out_o = out_r;
   assign sys_clk_oe_o = oe_r;

   ////////////////////////////////////////////////////////////////////
   // Bus master clock. The prohibited 11X codes fall back to full
   // speed so a bad write can never freeze the bus master.
   assign sel = scc_r[`CGC_SCC_SEL_HI:`CGC_SCC_SEL_LO];

   always_comb begin
      tap_mask = '0;
      if (sel[2:1] != `CGC_SEL_BAD_HI) begin
         tap_mask = (`CGC_DIV_W'(1) << sel) - 1'b1;
      end
   end

   // One enable pulse every 2**sel cycles of the system clock.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         bm_en_r <= 1'b1;
         bm_div_r <= `CGC_SEL_FULL;
      end else begin
         bm_en_r <= ((div.count & tap_mask) == tap_mask);
         bm_div_r <= (sel[2:1] == `CGC_SEL_BAD_HI) ? `CGC_SEL_FULL : sel;
      end
   end

   assign bm_clk_en_o = bm_en_r;
   assign bm_clk_div_o = bm_div_r;

   ////////////////////////////////////////////////////////////////////
   // Subclock enable straight from the disable bit.
   assign div.sub_enable = ~lpc_r[`CGC_LPC_SUBOFF_BIT];
   assign sub_clk_o = div.sub_clk;
   assign sub_clk_en_o = div.sub_enable;

   ////////////////////////////////////////////////////////////////////
   // Feedback resistor. The cut setting only moves at the standby
   // boundary, because changing it mid-run could kill a crystal.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fb_cut_r <= 1'b0;
      end else if (enter_sby | leave_sby) begin
         fb_cut_r <= lpc_r[`CGC_LPC_FBCUT_BIT];
      end
   end

   // Resistor on only while oscillating and not cut.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fb_on_r <= 1'b0;
      end else begin
         fb_on_r <= ~fb_cut_r & ~osc_stopped;
      end
   end

   assign feedback_on_o = fb_on_r;

   ////////////////////////////////////////////////////////////////////
   // Multiplier. A prohibited code is never applied; the old factor
   // stays, which keeps the PLL inside its lock range.
   assign mul_req = lpc_r[`CGC_LPC_MUL_HI:`CGC_LPC_MUL_LO];
   assign mul_ok = (mul_req != `CGC_MUL_BAD);

   // Settling load value: unit scaled by the standby settling bits.
   always_comb begin
      settle_nxt = settle_r;
      if (leave_sby) begin
         settle_nxt = `CGC_SETTLE_W'(SETTLE_UNIT << settle_time_i);
      end else if (settle_r != '0) begin
         settle_nxt = settle_r - 1'b1;
      end
   end

   // Sequencer for deferred switching and the settling wait.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pll_st_r <= CGC_PLL_RUN;
         settle_r <= '0;
      end else begin
         settle_r <= settle_nxt;
         case (pll_st_r)
            CGC_PLL_RUN: begin
               if (enter_sby) begin
                  pll_st_r <= CGC_PLL_STANDBY;
               end
            end
            CGC_PLL_STANDBY: begin
               if (leave_sby) begin
                  pll_st_r <= CGC_PLL_SETTLE;
               end
            end
            CGC_PLL_SETTLE: begin
               if (enter_sby) begin
                  pll_st_r <= CGC_PLL_STANDBY;
               end else if (settle_r == '0) begin
                  pll_st_r <= CGC_PLL_RUN;
               end
            end
            default: pll_st_r <= CGC_PLL_RUN;
         endcase
      end
   end

   // Applied factor: at the standby entry, or at the edge at which the
   // write lands when immediate switching is selected. Each path checks
   // its own code, so an old prohibited value never blocks a good write.
   assign mul_wr = wb_dat_i[`CGC_LPC_MUL_HI:`CGC_LPC_MUL_LO];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pll_factor_r <= 2'h0;
      end else if (scc_r[`CGC_SCC_SWMODE_BIT] & wr_lpc &
                   (mul_wr != `CGC_MUL_BAD)) begin
         pll_factor_r <= mul_wr;
      end else if (~scc_r[`CGC_SCC_SWMODE_BIT] & enter_sby & mul_ok) begin
         pll_factor_r <= mul_req;
      end
   end

   assign pll_factor_o = pll_factor_r;
   assign pll_settling_o = (pll_st_r == CGC_PLL_SETTLE);

endmodule : cgc_top
`default_nettype wire

// >>> test/cgc_props.sv
/* Checker on the ports of cgc_top.
 Assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ns
`default_nettype none
`include "cgc_consts.svh"
module cgc_props
   import cgc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire cgc_mode_t mode_i,
   input wire logic sys_clk_pass_o,
   input wire logic sys_clk_out_o,
   input wire logic sys_clk_oe_o,
   input wire logic bm_clk_en_o,
   input wire logic [2:0] bm_clk_div_o,
   input wire logic sub_clk_o,
   input wire logic sub_clk_en_o,
   input wire logic feedback_on_o,
   input wire logic [1:0] pll_factor_o,
   input wire logic pll_settling_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [7:0] scc_r;
   logic wr_b;
   logic imm;
   logic act;
   //////////////////////////////
   // Shadow of the control byte, so the pin and select can be predicted.
   assign wr_b = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign imm = wr_b && wb_adr_i == `CGC_OFS_LPC && scc_r[3];
   assign act = mode_i <= CGC_MODE_SUBSLEEP;
   always_ff @(posedge clock_i) begin
      if (rst_i)
         scc_r <= 8'h00;
      else if (wr_b && wb_adr_i == `CGC_OFS_SCC)
         scc_r <= wb_dat_i[7:0];
   end
   //////////////////////////////
   // A one-cycle ack matters: a level ack would answer twice.
   chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
   chk_pin_active: assert property (act |=> sys_clk_oe_o &&
      sys_clk_pass_o == !$past(scc_r[7]) &&
      (sys_clk_pass_o || sys_clk_out_o)) else $error("pin wrong");
   chk_pin_held: assert property (mode_i inside {CGC_MODE_WATCH,
      CGC_MODE_SW_STANDBY, CGC_MODE_DIRECT} |=> !sys_clk_pass_o &&
      sys_clk_out_o && sys_clk_oe_o) else $error("pin not held high");
   chk_pin_hiz: assert property (mode_i == CGC_MODE_HW_STANDBY |=>
      !sys_clk_oe_o && !sys_clk_pass_o) else $error("pin driven");
   chk_bm_select: assert property (1'h1 |=> bm_clk_div_o ==
      ($past(scc_r[2:1]) == 2'h3 ? 3'h0 : $past(scc_r[2:0])))
      else $error("bus clock select wrong");
   chk_bm_full: assert property (bm_clk_div_o == 3'h0 |->
      bm_clk_en_o) else $error("full speed enable low");
   chk_bm_half: assert property (bm_clk_div_o == 3'h1 ##1
      bm_clk_div_o == 3'h1 |-> bm_clk_en_o != $past(bm_clk_en_o))
      else $error("half rate enable wrong");
   chk_sub_off: assert property (!sub_clk_en_o |=> !sub_clk_o)
      else $error("subclock runs while disabled");
   chk_sub_rate: assert property ($fell(sub_clk_o) && sub_clk_en_o
      |-> ##63 (!sub_clk_o || !sub_clk_en_o) ##1
      (sub_clk_o || !sub_clk_en_o)) else $error("subclock period wrong");
   chk_pll_now: assert property (imm && wb_dat_i[1:0]
      != 2'h3 |=> pll_factor_o == $past(wb_dat_i[1:0]))
      else $error("not applied");
   chk_pll_when: assert property ($changed(pll_factor_o)
      |-> pll_factor_o != 2'h3 && ($past(mode_i) == CGC_MODE_SW_STANDBY ||
      $past(imm))) else $error("multiplier changed early");
   chk_fb_stop: assert property (mode_i inside {CGC_MODE_WATCH,
      CGC_MODE_SW_STANDBY, CGC_MODE_HW_STANDBY} |=> !feedback_on_o)
      else $error("feedback on while stopped");
   chk_settle_wait: assert property (
      $past(mode_i) == CGC_MODE_SW_STANDBY && act && !scc_r[3]
      |=> pll_settling_o ##[1:100] !pll_settling_o)
      else $error("settle wait wrong");
   cov_imm: cover property (imm);
   cov_settle: cover property ($rose(pll_settling_o));
   cov_hiz: cover property (!sys_clk_oe_o);
endmodule : cgc_props
bind cgc_top cgc_props u_props (.clock_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .mode_i,
   .sys_clk_pass_o, .sys_clk_out_o, .sys_clk_oe_o, .bm_clk_en_o,
   .bm_clk_div_o, .sub_clk_o, .sub_clk_en_o, .feedback_on_o,
   .pll_factor_o, .pll_settling_o);
`default_nettype wire

// >>> test/tb_top.sv
/* Bench for cgc_top: Wishbone access tasks and test sequences.
 Assumes cgc_consts.svh on the include path and the checker bound in. */
`timescale 1ns/1ns
`default_nettype none
`include "cgc_consts.svh"
module tb_top
   import cgc_pkg::*;
;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cyc = 1'h0;
   logic we = 1'h0;
   logic s0 = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [31:0] dat_o;
   logic [31:0] rdat;
   logic ack, pass, out, oe, bmen, sub, suben, fb, setl;
   logic [2:0] bmdiv;
   logic [1:0] fac;
   cgc_mode_t mode = CGC_MODE_HIGH;
   logic [2:0] sts = 3'h1;
   int failures = 0;
   int tests_run = 0;
   int ticks = 0;
   // A short settle unit keeps each standby exit wait to 8 or 16 cycles.
   localparam int UNIT = 4;
   cgc_top #(.SETTLE_UNIT(UNIT)) dut (.clock_i(clk), .rst_i(rst),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i({3'h0, s0}), .wb_dat_i({24'h0, wd}), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .mode_i(mode), .settle_time_i(sts),
      .sys_clk_pass_o(pass), .sys_clk_out_o(out), .sys_clk_oe_o(oe),
      .bm_clk_en_o(bmen), .bm_clk_div_o(bmdiv), .sub_clk_o(sub),
      .sub_clk_en_o(suben), .feedback_on_o(fb), .pll_factor_o(fac),
      .pll_settling_o(setl));
   //////////////////////////////
   // Clock and a cycle ceiling well above the whole run.
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      ticks <= ticks + 1;
      if (ticks == 30000) begin
         failures++;
         wrap_up();
      end
   end
   //////////////////////////////
   // Checks are case compares so that an unknown never matches.
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tk(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk
   // Holds the request until ack is sampled; read data taken at that edge.
   task automatic bus(logic w, logic [7:0] a, logic [7:0] d, logic s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      wd <= d;
      s0 <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      rdat = dat_o;
      cyc <= 1'h0;
      if (n >= 20)
         chk("ack", 32'h1, 32'h0);
   endtask : bus
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'h1, a, d, 1'h1);
   endtask : wr
   task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
      bus(1'h0, a, 8'h00, 1'h1);
      chk(nm, e, rdat);
   endtask : rdc
   task automatic until_sub(logic v, output int n);
      n = 0;
      while (sub !== v && n < 300) begin
         tk(1);
         n++;
      end
   endtask : until_sub
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   //////////////////////////////
   // Test sequence.
   initial begin
      int c;
      int f;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      rdc("scc", `CGC_OFS_SCC, 32'h0);
      rdc("lpc", `CGC_OFS_LPC, 32'h0);
      tk(1);
      chk("outs", 32'h00f, {fac, bmdiv, suben, fb, pass, oe});
      $display("test reset ends");
      for (c = 0; c < 2; c++) begin
         wr(`CGC_OFS_SCC, c ? 8'hff : 8'h00);
         for (f = 0; f <= 8; f++) begin
            @(posedge clk);
            mode <= cgc_mode_t'(f);
            tk(2);
            chk("pin",
               {f <= 4 && c == 0, f != 7, 1'h1}, {pass, oe, out | pass});
         end
      end
      rdc("reserved", `CGC_OFS_SCC, 32'h8f);
      mode <= CGC_MODE_HIGH;
      $display("test pin ends");
      // Every select code, the prohibited pair acting as full speed.
      for (c = 0; c < 8; c++) begin
         wr(`CGC_OFS_SCC, c[7:0]);
         tk(3);
         f = 0;
         repeat (64) begin
            f += bmen;
            tk(1);
         end
         chk("div", c > 5 ? 0 : c, bmdiv);
         chk("rate", c > 5 ? 64 : 64 >> c, f);
      end
      wr(8'h0c, 8'hff);
      rdc("unmapped", 8'h0c, 32'h0);
      bus(1'h1, `CGC_OFS_SCC, 8'h83, 1'h0);
      rdc("lane", `CGC_OFS_SCC, 32'h07);
      $display("test select ends");
      wr(`CGC_OFS_SCC, 8'h08);
      for (c = 0; c < 4; c++) begin
         wr(`CGC_OFS_LPC, c[7:0]);
         tk(1);
         chk("imm", c == 3 ? 2 : c, fac);
      end
      $display("test immediate ends");
      // Two deferred switches, each with its own settling selection.
      wr(`CGC_OFS_SCC, 8'h00);
      for (c = 1; c < 3; c++) begin
         wr(`CGC_OFS_LPC, 8'h08 | c[7:0]);
         sts <= c[2:0];
         tk(4);
         chk("defer", {2'(3 - c), c == 1}, {fac, fb});
         @(posedge clk);
         mode <= CGC_MODE_SW_STANDBY;
         tk(2);
         chk("standby", {c[1:0], 1'h0}, {fac, fb});
         rdc("status", `CGC_OFS_STAT, 32'h36);
         @(posedge clk);
         mode <= CGC_MODE_HIGH;
         tk(2);
         chk("settle", 32'h1, setl);
         f = 0;
         while (setl !== 1'h0 && f < 200) begin
            tk(1);
            f++;
         end
         chk("settle len", 32'h1,
            f >= (UNIT << c) && f <= (UNIT << c) + 4);
         chk("cut", 32'h0, fb);
      end
      $display("test deferred ends");
      wr(`CGC_OFS_LPC, 8'h10);
      tk(2);
      f = 0;
      repeat (200) begin
         f += sub;
         tk(1);
      end
      chk("sub off", 32'h0, {suben, f[7:0]});
      wr(`CGC_OFS_LPC, 8'h00);
      until_sub(1'h1, c);
      until_sub(1'h0, c);
      until_sub(1'h1, c);
      chk("sub low", 64, c);
      until_sub(1'h0, c);
      chk("sub high", 64, c);
      $display("test subclock ends");
      wr(`CGC_OFS_SCC, 8'h8b);
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rdc("scc again", `CGC_OFS_SCC, 32'h0);
      rdc("lpc again", `CGC_OFS_LPC, 32'h0);
      tk(1);
      chk("outs again", 32'h00f, {fac, bmdiv, suben, fb, pass, oe});
      $display("test second reset ends");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
